//--- src/uart_ctl_params.svh
`ifndef UART_CTL_PARAMS_SVH
`define UART_CTL_PARAMS_SVH

// Register byte addresses (index times four)
`define IDX_CONTROL      8'hf1
`define IDX_DATA         8'hf2
`define IDX_OWN_ADDR     8'hf3
`define IDX_ADDR_MASK    8'hae
`define IDX_POWER_CTL    8'h87
`define IDX_TIMER_CTL    8'h8e
`define IDX_RELOAD       8'h8d
`define ADDR_CONTROL     12'h3c4
`define ADDR_DATA        12'h3c8
`define ADDR_OWN_ADDR    12'h3cc
`define ADDR_ADDR_MASK   12'h2b8
`define ADDR_POWER_CTL   12'h21c
`define ADDR_TIMER_CTL   12'h238
`define ADDR_RELOAD      12'h234

// Control register fields
`define BIT_MODE_HI      7
`define BIT_MODE_LO      6
`define BIT_MULTIPROC    5
`define BIT_RX_EN        4
`define BIT_TX9          3
`define BIT_RX9          2
`define BIT_TX_DONE      1
`define BIT_RX_DONE      0

// Power control fields
`define BIT_DOUBLER      7
`define BIT_VIEW_SEL     6
// Timer control field
`define BIT_T1_CLK       4

// Reset value and the timer reload top
`define RST_BYTE         8'h00
`define RELOAD_TOP       9'h1_00

// Fixed-rate divisors and the slow timer prescale
`define DIV_FIXED_FAST   16'h0020
`define DIV_FIXED_SLOW   16'h0040
`define DIV_MODE0        16'h000c
`define PRESCALE_SLOW    16'h000c

// Data bits per frame and the timer rate shifts
`define BITS_PLAIN       4'h8
`define BITS_NINE        4'h9
`define SHIFT_DOUBLED    4
`define SHIFT_PLAIN      5

`endif

//--- src/uart_ctl_pkg.sv
package uart_ctl_pkg;

  // Operating modes held in the two mode bits
  typedef enum logic [1:0] {
    MODE_SYNC,
    MODE_ASYNC8,
    MODE_ASYNC9_FIXED,
    MODE_ASYNC9_VAR
  } mode_t;

  // Serial shifter states
  typedef enum logic [1:0] {
    SH_IDLE,
    SH_START,
    SH_BITS,
    SH_STOP
  } shift_state_t;

endpackage : uart_ctl_pkg

//--- src/uart_baud_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctl_params.svh"

// Bit-time tick generator: one pclk pulse per serial bit
module uart_baud_gen
  import uart_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Rate selection
  input  wire logic [1:0] mode,
  input  wire logic       doubler,
  input  wire logic       t1_fast,
  input  wire logic [7:0] reload,
  // Tick out
  output var  logic       tick
);

  // All state of this module
  typedef struct packed {
    logic [16:0] cnt;   // Cycles left in the bit
    logic        tick;  // Registered tick
  } baud_state_t;

  baud_state_t st_r;
  baud_state_t st_nxt;
  logic [16:0] div;     // Cycles per bit, wide enough for the slow prescale

  // Divisor in modes 1 and 3: 16 or 32 cycles per timer step, times 12 on the slow timer clock
  always_comb begin
    logic [8:0]  span;
    logic [16:0] base;
    span = `RELOAD_TOP - {1'b0, reload};
    base = {8'h00, span} << (doubler ? `SHIFT_DOUBLED : `SHIFT_PLAIN);
    unique case (mode_t'(mode))
      MODE_SYNC:         div = {1'b0, `DIV_MODE0};
      MODE_ASYNC9_FIXED: div = doubler ? {1'b0, `DIV_FIXED_FAST} : {1'b0, `DIV_FIXED_SLOW};
      default:           div = t1_fast ? base : 17'(base * {1'b0, `PRESCALE_SLOW});
    endcase
  end

  // Down counter reloaded on expiry
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt <= 17'h0_0001) begin
      st_nxt.cnt  = div;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt - 17'h0_0001;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule : uart_baud_gen
`default_nettype wire

//--- src/uart_control_status.sv
// Notes on behaviour
// - Overrun when unread byte is replaced
// - Bit 6: mode low or overrun
// - Low stop bit sets frame error
// - Bit 7: mode high or frame error
// - View select chooses status or mode
// - Mode field picks one of four modes
// - Mode 1 multiproc needs high stop
// - Modes 2/3 filter ninth bit, address
// - Receive only while enabled
// - Ninth transmit bit from control bit 3
// - Ninth receive bit loaded per mode
// - Transmit done at stop start
// - Receive done set, software clears
// - Done flags request interrupt
// - Timer-derived bit rate formula
// - Data write while busy: collision
// - Data write sends, read returns latch
// - Address mask selects compared bits
// - Broadcast is address OR mask
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctl_params.svh"

module uart_control_status
  import uart_ctl_pkg::*;
(
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Serial line
  input  wire logic        rx_line,
  output var  logic        tx_line,
  // Interrupt request to the core
  input  wire logic        port_irq_enable,
  output var  logic        port_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  // One packed struct holds every register of the block except the bit timer in u_baud
  typedef struct packed {
    logic [7:0]   ctrl;       // Control byte, bits 7..6 hold mode
    logic         fe;         // Frame error
    logic         ovr;        // Receive overrun
    logic         col;        // Transmit collision
    logic [7:0]   power;      // Power control byte
    logic [7:0]   tmr;        // Timer clock control
    logic [7:0]   reload;     // Timer reload byte
    logic [7:0]   own;        // Own address
    logic [7:0]   mask;       // Address mask
    logic [7:0]   rx_latch;   // Receive latch
    logic         unread;     // Latch not yet read
    shift_state_t tx_st;      // Transmitter state
    logic [8:0]   tx_sh;      // Transmit shifter
    logic [3:0]   tx_cnt;     // Bits left
    shift_state_t rx_st;      // Receiver state
    logic [8:0]   rx_sh;      // Receive shifter
    logic [3:0]   rx_cnt;     // Bits left
    logic         line;       // Serial output
    logic [31:0]  rdata;      // Read data
    logic         ready;      // Access phase answer
    logic         err;        // Unmapped address
    logic         irq;        // Interrupt request
  } ctl_state_t;

  ctl_state_t st_r;
  ctl_state_t st_nxt;
  logic       tick;           // One bit time elapsed
  mode_t      mode;           // Decoded mode
  logic       view;           // Status view select

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Masked match of a received byte against a reference
  // Bits whose mask bit is zero are don't care
  function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] ref_a,
                                    input logic [7:0] msk);
    addr_hit = ((rx ^ ref_a) & msk) == 8'h00;
  endfunction : addr_hit

  // Known register address decode
  // Any other address is refused with an error
  function automatic logic mapped(input logic [11:0] a);
    mapped = a == `ADDR_CONTROL || a == `ADDR_DATA || a == `ADDR_OWN_ADDR ||
             a == `ADDR_ADDR_MASK || a == `ADDR_POWER_CTL ||
             a == `ADDR_TIMER_CTL || a == `ADDR_RELOAD;
  endfunction : mapped

  // Data bits in a frame: eight, or nine in the 9-bit modes
  function automatic logic [3:0] frame_bits(input logic ninth);
    frame_bits = ninth ? `BITS_NINE : `BITS_PLAIN;
  endfunction : frame_bits

  ////////////////////////////////////////////////////////////////////////////
  // Bit timing

  assign mode = mode_t'({st_r.ctrl[`BIT_MODE_HI], st_r.ctrl[`BIT_MODE_LO]});
  // View select lives in the power control byte
  assign view = st_r.power[`BIT_VIEW_SEL];

  // One bit tick shared by transmitter and receiver
  // timer rate
  uart_baud_gen u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .mode    (mode),
    .doubler (st_r.power[`BIT_DOUBLER]),
    .t1_fast (st_r.tmr[`BIT_T1_CLK]),
    .reload  (st_r.reload),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic       acc;      // APB setup seen
    logic       wr_data;  // Write to data register
    logic       set_tx;   // Transmit done event
    logic       set_rx;   // Receive done event
    logic       set_fe;   // Frame error event
    logic       set_ovr;  // Overrun event
    logic       set_col;  // Collision event
    logic       accept;   // Frame passes filter
    logic       stop_b;   // Sampled stop bit
    logic       nine;     // Ninth data bit in use
    logic [7:0] w;        // Write byte
    acc     = psel && !penable;
    w       = pwdata[7:0];
    wr_data = acc && pwrite && paddr == `ADDR_DATA;
    set_tx  = 1'b0;
    set_rx  = 1'b0;
    set_fe  = 1'b0;
    set_ovr = 1'b0;
    set_col = 1'b0;
    accept  = 1'b0;
    stop_b  = rx_line;
    nine    = mode == MODE_ASYNC9_FIXED || mode == MODE_ASYNC9_VAR;
    // Hold every register unless a branch below changes it
    st_nxt  = st_r;
    st_nxt.ready = acc;
    st_nxt.err   = acc && !mapped(paddr);

    // Register writes taken in the setup cycle
    // The access cycle only carries the registered answer
    if (acc && pwrite) begin
      unique case (paddr)
        `ADDR_CONTROL: begin
          if (view) begin
            st_nxt.fe  = w[`BIT_MODE_HI];
            st_nxt.ovr = w[`BIT_MODE_LO];
            st_nxt.col = w[`BIT_MULTIPROC];
            st_nxt.ctrl[4:0] = w[4:0];
          end else begin
            st_nxt.ctrl = w;
          end
        end
        `ADDR_OWN_ADDR:  st_nxt.own    = w;
        `ADDR_ADDR_MASK: st_nxt.mask   = w;
        `ADDR_POWER_CTL: st_nxt.power  = w;
        `ADDR_TIMER_CTL: st_nxt.tmr    = w;
        `ADDR_RELOAD:    st_nxt.reload = w;
        default: ;
      endcase
    end

    // Register reads
    // Read data is registered here and stands in the access cycle
    if (acc && !pwrite) begin
      // Unmapped reads return zero
      st_nxt.rdata = 32'h0000_0000;
      unique case (paddr)
        `ADDR_CONTROL: begin
          st_nxt.rdata[7:0] = st_r.ctrl;
          if (view) begin
            st_nxt.rdata[`BIT_MODE_HI]   = st_r.fe;
            st_nxt.rdata[`BIT_MODE_LO]   = st_r.ovr;
            st_nxt.rdata[`BIT_MULTIPROC] = st_r.col;
          end
        end
        `ADDR_DATA: begin
          st_nxt.rdata[7:0] = st_r.rx_latch;
          st_nxt.unread     = 1'b0;
        end
        `ADDR_OWN_ADDR:  st_nxt.rdata[7:0] = st_r.own;
        `ADDR_ADDR_MASK: st_nxt.rdata[7:0] = st_r.mask;
        `ADDR_POWER_CTL: st_nxt.rdata[7:0] = st_r.power;
        `ADDR_TIMER_CTL: st_nxt.rdata[7:0] = st_r.tmr;
        `ADDR_RELOAD:    st_nxt.rdata[7:0] = st_r.reload;
        default: ;
      endcase
    end

    // Transmitter
    // busy write
    if (wr_data && st_r.tx_st != SH_IDLE) begin
      set_col = 1'b1;
    end
    // A collision write must not swallow the tick of the running frame
    if (wr_data && st_r.tx_st == SH_IDLE) begin
      st_nxt.tx_sh  = {st_r.ctrl[`BIT_TX9], w};
      st_nxt.tx_cnt = frame_bits(nine);
      st_nxt.tx_st  = SH_START;
    end else if (tick) begin
      unique case (st_r.tx_st)
        SH_IDLE: st_nxt.line = 1'b1;
        // Start bit low, or first data bit in the synchronous mode
        SH_START: begin
          st_nxt.line  = mode == MODE_SYNC ? st_r.tx_sh[0] : 1'b0;
          st_nxt.tx_st = SH_BITS;
          if (mode == MODE_SYNC) begin
            st_nxt.tx_sh  = {1'b0, st_r.tx_sh[8:1]};
            st_nxt.tx_cnt = st_r.tx_cnt - 4'h1;
          end
        end
        SH_BITS: begin
          if (st_r.tx_cnt == 4'h0) begin
            set_tx       = 1'b1;
            st_nxt.line  = 1'b1;
            st_nxt.tx_st = mode == MODE_SYNC ? SH_IDLE : SH_STOP;
          end else begin
            st_nxt.line   = st_r.tx_sh[0];
            st_nxt.tx_sh  = {1'b0, st_r.tx_sh[8:1]};
            st_nxt.tx_cnt = st_r.tx_cnt - 4'h1;
          end
        end
        // Stop bit lasts one tick, then idle
        SH_STOP: st_nxt.tx_st = SH_IDLE;
      endcase
    end

    // Receiver, asynchronous modes only
    // One sample per bit, in the phase at which the start bit was seen
    // A frame already running finishes even if reception is disabled
    if (tick && mode != MODE_SYNC) begin
      unique case (st_r.rx_st)
        SH_IDLE: begin
          if (st_r.ctrl[`BIT_RX_EN] && !rx_line) begin
            st_nxt.rx_st  = SH_BITS;
            st_nxt.rx_cnt = frame_bits(nine);
          end
        end
        SH_BITS: begin
          st_nxt.rx_sh  = {rx_line, st_r.rx_sh[8:1]};
          st_nxt.rx_cnt = st_r.rx_cnt - 4'h1;
          if (st_r.rx_cnt == 4'h1) st_nxt.rx_st = SH_STOP;
        end
        SH_STOP: begin
          st_nxt.rx_st = SH_IDLE;
          set_fe = !stop_b;
          if (nine) begin
            accept = !st_r.ctrl[`BIT_MULTIPROC] ||
                     (st_r.rx_sh[8] &&
                      (addr_hit(st_r.rx_sh[7:0], st_r.own, st_r.mask) ||
                       addr_hit(st_r.rx_sh[7:0], st_r.own | st_r.mask,
                                st_r.own | st_r.mask)));
          end else begin
            accept = !st_r.ctrl[`BIT_MULTIPROC] || stop_b;
          end
          // Latch is left alone while the previous byte is still flagged
          if (accept && !st_r.ctrl[`BIT_RX_DONE]) begin
            st_nxt.rx_latch = nine ? st_r.rx_sh[7:0] : st_r.rx_sh[8:1];
            if (nine) begin
              st_nxt.ctrl[`BIT_RX9] = st_r.rx_sh[8];
            end else if (!st_r.ctrl[`BIT_MULTIPROC]) begin
              st_nxt.ctrl[`BIT_RX9] = stop_b;
            end
            set_ovr       = st_r.unread;
            set_rx        = 1'b1;
            st_nxt.unread = 1'b1;
          end
        end
        default: st_nxt.rx_st = SH_IDLE;
      endcase
    end

    // Events win over software clears
    // A clear written in the same cycle as an event loses
    if (set_fe)  st_nxt.fe  = 1'b1;
    if (set_ovr) st_nxt.ovr = 1'b1;
    if (set_col) st_nxt.col = 1'b1;
    if (set_tx)  st_nxt.ctrl[`BIT_TX_DONE] = 1'b1;
    if (set_rx)  st_nxt.ctrl[`BIT_RX_DONE] = 1'b1;

    // Level request, follows the enable one cycle later
    // interrupt request
    st_nxt.irq = port_irq_enable &&
                 (st_nxt.ctrl[`BIT_TX_DONE] || st_nxt.ctrl[`BIT_RX_DONE]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Line idles high, everything else clears
  // zero after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= '0;
      st_r.line <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Every output is a field of the state register
  assign prdata   = st_r.rdata;
  assign pready   = st_r.ready;
  assign pslverr  = st_r.err;
  assign tx_line  = st_r.line;
  assign port_irq = st_r.irq;

endmodule : uart_control_status
`default_nettype wire

//--- verification/uart_ctl_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctl_params.svh"

module uart_ctl_chk (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial line and interrupt
  input wire logic        rx_line,
  input wire logic        tx_line,
  input wire logic        port_irq_enable,
  input wire logic        port_irq
);
  logic       xfer;      // Completed transfer
  logic       mapped;    // Address is the control, data, own address or mask register
  logic       touched_r; // Control or data written since reset
  logic [7:0] own_r;     // Last own address written

  assign xfer = psel && penable && pready;
  assign mapped = paddr == `ADDR_CONTROL || paddr == `ADDR_DATA
               || paddr == `ADDR_OWN_ADDR || paddr == `ADDR_ADDR_MASK;

  // Shadow of software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      touched_r <= 1'b0;
      own_r     <= 8'h00;
    end else if (xfer && pwrite) begin
      if (paddr == `ADDR_CONTROL || paddr == `ADDR_DATA) begin
        touched_r <= 1'b1;
      end
      if (paddr == `ADDR_OWN_ADDR) begin
        own_r <= pwdata[7:0];
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_READY_NEXT: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("answer held too long");
  AST_MAPPED_OK: assert property (xfer && mapped |-> !pslverr)
    else $error("error on mapped register");
  AST_UNMAPPED_ZERO: assert property (xfer && !pwrite && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  AST_IRQ_EN: assert property (!port_irq_enable |=> !port_irq)
    else $error("interrupt while disabled");
  AST_CTL_RESET: assert property (xfer && !pwrite && paddr == `ADDR_CONTROL && !touched_r
    |-> prdata == 32'h0000_0000)
    else $error("control not zero after reset");
  AST_OWN_RB: assert property (xfer && !pwrite && paddr == `ADDR_OWN_ADDR
    |-> prdata[7:0] == own_r)
    else $error("own address readback wrong");

  cover property (xfer && pslverr);
  cover property ($rose(port_irq));
  cover property (xfer && !pwrite && paddr == `ADDR_CONTROL && prdata[6]);
endmodule : uart_ctl_chk

bind uart_control_status uart_ctl_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_line(rx_line), .tx_line(tx_line),
  .port_irq_enable(port_irq_enable), .port_irq(port_irq));
`default_nettype wire

//--- verification/uart_remote_node.sv
`timescale 1ns/1ps
`default_nettype none

// Far serial node: sends frames and captures the block's frames
module uart_remote_node (
  // Clock
  input  wire logic pclk,
  // Serial lines seen from the far end
  input  wire logic ser_in,
  output var  logic ser_out
);
  // Line idles high between frames
  initial ser_out = 1'b1;

  // start, data LSB first, optional ninth, stop
  task automatic send(input int per, input logic nine, input logic [7:0] d,
                      input logic b9, input logic stp);
    logic [10:0] f;
    f = {stp, b9, d, 1'b0};
    if (!nine) begin
      f[9] = stp;
    end
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge pclk);
      ser_out <= f[i];
      repeat (per - 1) @(posedge pclk);
    end
    @(posedge pclk);
    ser_out <= 1'b1;
  endtask : send

  // Measures start bit length, then samples mid-bit
  task automatic catch(input int per, input logic nine, output logic [7:0] d,
                       output logic b9, output int slen);
    int k;
    k = 0;
    slen = 0;
    while (ser_in !== 1'b0 && k < 9000) begin
      @(posedge pclk);
      k++;
    end
    while (ser_in === 1'b0 && slen < 9000) begin
      @(posedge pclk);
      slen++;
    end
    repeat (per / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      d[i] = ser_in;
      repeat (per) @(posedge pclk);
    end
    b9 = nine ? ser_in : 1'b0;
  endtask : catch
endmodule : uart_remote_node
`default_nettype wire

//--- verification/uart_control_status_errors_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "uart_ctl_params.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module uart_control_status_errors_tb import uart_ctl_pkg::*;;
  localparam logic [11:0] CTL = `ADDR_CONTROL;
  localparam logic [11:0] DAT = `ADDR_DATA;
  localparam logic [11:0] PWR = `ADDR_POWER_CTL;
  typedef struct packed {logic [7:0] ctl; logic [7:0] dat; logic b9; logic stp; logic ok;} rx_case_t;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        rx_line, tx_line, port_irq_enable, port_irq, last_err, c9;
  logic [7:0]  rd8, cd;
  int          n_errors, tests_run, sl;
  rx_case_t    tbl [9];

  uart_control_status dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_line(rx_line), .tx_line(tx_line),
    .port_irq_enable(port_irq_enable), .port_irq(port_irq));
  uart_remote_node rmt_u (.pclk(pclk), .ser_in(tx_line), .ser_out(rx_line));

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // One bus transfer: setup, access until ready
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) n_errors++;
    rd8 = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  // Frame from the far node, then room for the receiver
  task automatic rx(input int per, input logic nine, input logic [7:0] d, input logic b9,
                    input logic s);
    rmt_u.send(per, nine, d, b9, s);
    repeat (2 * per) @(posedge pclk);
  endtask : rx

  task automatic report_and_stop;
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // Hang guard
  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    report_and_stop;
  end

  initial begin
    {presetn, psel, penable, pwrite, port_irq_enable} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    n_errors = 0;
    tests_run = 0;
    tbl = '{'{8'h70, 8'h11, 1'b0, 1'b0, 1'b0},  // low stop refused
            '{8'h70, 8'h22, 1'b0, 1'b1, 1'b1},  // high stop taken
            '{8'h40, 8'h33, 1'b0, 1'b1, 1'b0},  // receiver off
            '{8'hF0, 8'h12, 1'b1, 1'b1, 1'b0},  // address mismatch
            '{8'hF0, 8'h25, 1'b0, 1'b1, 1'b0},  // data byte ignored
            '{8'hF0, 8'h25, 1'b1, 1'b1, 1'b1},  // masked match
            '{8'hF0, 8'hFF, 1'b1, 1'b1, 1'b1},  // broadcast
            '{8'hD0, 8'h5A, 1'b0, 1'b1, 1'b1},  // filter off
            '{8'hB0, 8'h25, 1'b1, 1'b1, 1'b1}}; // fixed rate mode
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    bus(0, CTL, 8'h00);
    `CHK(rd8, 8'h00)
    bus(0, 12'h000, 8'h00);
    `CHK({last_err, rd8}, 9'h100)
    bus(1, `ADDR_OWN_ADDR, 8'h35);
    bus(1, `ADDR_ADDR_MASK, 8'h0F);
    bus(0, `ADDR_OWN_ADDR, 8'h00);
    `CHK({last_err, rd8}, 9'h035)
    bus(0, `ADDR_ADDR_MASK, 8'h00);
    `CHK(rd8, 8'h0F)
    // Sixteen clocks per bit: doubler, fast timer, top reload
    bus(1, PWR, 8'h80);
    bus(1, `ADDR_TIMER_CTL, 8'h10);
    bus(1, `ADDR_RELOAD, 8'hFF);
    // Mode 3 send with ninth bit set, second write collides
    bus(1, CTL, 8'hC8);
    port_irq_enable <= 1'b1;
    fork
      rmt_u.catch(16, 1'b1, cd, c9, sl);
      begin
        bus(1, DAT, 8'hA5);
        repeat (20) @(posedge pclk);
        bus(1, DAT, 8'h5A);
      end
    join
    `CHK(sl, 16)
    `CHK(cd, 8'hA5)
    `CHK(c9, 1'b1)
    repeat (16) @(posedge pclk);
    bus(0, CTL, 8'h00);
    `CHK(rd8, 8'hCA)
    `CHK(port_irq, 1'b1)
    port_irq_enable <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK(port_irq, 1'b0)
    bus(1, PWR, 8'hC0);
    bus(0, CTL, 8'h00);
    `CHK(rd8 & 8'h20, 8'h20)
    // Mode 1 receive, then unread byte replaced with low stop
    bus(1, PWR, 8'h80);
    bus(1, CTL, 8'h50);
    rx(16, 1'b0, 8'h3C, 1'b0, 1'b1);
    bus(0, CTL, 8'h00);
    `CHK(rd8, 8'h55)
    bus(0, DAT, 8'h00);
    `CHK(rd8, 8'h3C)
    bus(1, CTL, 8'h50);
    rx(16, 1'b0, 8'h81, 1'b0, 1'b1);
    bus(1, CTL, 8'h50);
    rx(16, 1'b0, 8'h7E, 1'b0, 1'b0);
    bus(1, PWR, 8'hC0);
    bus(0, CTL, 8'h00);
    `CHK(rd8[6], 1'b1)
    `CHK(rd8[7], 1'b1)
    // Clear status, mode bits must survive
    bus(1, CTL, 8'h10);
    bus(0, CTL, 8'h00);
    `CHK(rd8 & 8'hE0, 8'h00)
    bus(1, PWR, 8'h80);
    bus(0, CTL, 8'h00);
    `CHK(rd8 & 8'hC0, 8'h40)
    // Mode 0 send: done only after the eighth bit
    bus(1, CTL, 8'h00);
    bus(1, DAT, 8'h96);
    bus(0, CTL, 8'h00);
    `CHK(rd8, 8'h00)
    repeat (130) @(posedge pclk);
    bus(0, CTL, 8'h00);
    `CHK(rd8, 8'h02)
    // Filtering table
    foreach (tbl[i]) begin
      bus(1, CTL, tbl[i].ctl);
      rx(tbl[i].ctl[7:6] == 2'b10 ? 32 : 16, tbl[i].ctl[7], tbl[i].dat, tbl[i].b9, tbl[i].stp);
      bus(0, CTL, 8'h00);
      `CHK(rd8[0], tbl[i].ok)
      if (tbl[i].ok) begin
        bus(0, DAT, 8'h00);
        `CHK(rd8, tbl[i].dat)
      end
    end
    report_and_stop;
  end
endmodule : uart_control_status_errors_tb
`default_nettype wire
